// ### shared/fsg_pkg.sv
package fsg_pkg;

  // Flash access kinds seen by the guard
  typedef enum logic [1:0] {
    FSG_OP_READ,
    FSG_OP_WRITE,
    FSG_OP_ERASE_PAGE,
    FSG_OP_ERASE_ALL
  } fsg_op_e;

  // Outcome of one access
  typedef enum logic [1:0] {
    FSG_PERMIT,
    FSG_IGNORE,
    FSG_FAULT
  } fsg_verdict_e;

  localparam int unsigned FSG_ADDR_W       = 14;
  localparam int unsigned FSG_PAGE_LSB     = 9;
  localparam int unsigned FSG_PAGE_W       = FSG_ADDR_W - FSG_PAGE_LSB;
  localparam int unsigned FSG_PAGE_BYTES   = 512;

  localparam logic [13:0] FSG_LOCK_PAGE_BIG  = 14'h3C00;
  localparam logic [13:0] FSG_LOCK_PAGE_END_BIG = 14'h3DFF;
  localparam logic [13:0] FSG_LOCK_PAGE_SML  = 14'h1E00;
  localparam logic [13:0] FSG_LOCK_PAGE_END_SML = 14'h1FFF;
  localparam logic [13:0] FSG_RSV_BASE_BIG   = 14'h3E00;
  localparam logic [13:0] FSG_RSV_BASE_SML   = 14'h2000;
  localparam logic [7:0]  FSG_LOCK_ERASED    = 8'hFF;

  // Register map, byte addresses
  localparam logic [7:0]  FSG_REG_STORE_CTRL = 8'h00;
  localparam logic [7:0]  FSG_REG_RST_SRC    = 8'h04;
  localparam logic [7:0]  FSG_REG_STATUS     = 8'h08;

  localparam int unsigned FSG_SWE_BIT        = 0;
  localparam int unsigned FSG_SEE_BIT        = 1;
  localparam int unsigned FSG_POR_BIT        = 0;
  localparam int unsigned FSG_FERR_BIT       = 1;
  localparam int unsigned FSG_ST_LOCK_LSB    = 0;
  localparam int unsigned FSG_ST_ANY_BIT     = 8;
  localparam int unsigned FSG_ST_WRITTEN_BIT = 9;
  localparam int unsigned FSG_ST_BUSY_BIT    = 10;

  localparam logic [1:0]  FSG_STORE_CTRL_RST = 2'h0;
  localparam logic [1:0]  FSG_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  FSG_RESP_SLVERR    = 2'h2;

  // Page p is locked when it lies below the locked-page count
  function automatic logic fsg_page_locked(input logic [4:0] page,
                                           input logic [7:0] n);
    return {3'h0, page} < n;
  endfunction : fsg_page_locked

endpackage : fsg_pkg

// ### shared/fsg_req_if.sv
`timescale 1ns/10ps
interface fsg_req_if;
  import fsg_pkg::*;
  logic               is_dbg;
  fsg_op_e            op;
  logic [13:0]        addr;
  logic [13:0]        pc_addr;
  logic [7:0]         lock_n;
  logic               lock_written;
  logic               big_flash;
  fsg_verdict_e       verdict;

  modport guard (output is_dbg, op, addr, pc_addr, lock_n, lock_written,
                 big_flash, input verdict);
  modport judge (input is_dbg, op, addr, pc_addr, lock_n, lock_written,
                 big_flash, output verdict);
endinterface : fsg_req_if

// ### rtl/fsg_judge.sv
`timescale 1ns/10ps
module fsg_judge
  import fsg_pkg::*;
(
  fsg_req_if.judge rq
);

  logic [13:0] lock_base;
  logic [13:0] lock_byte;
  logic [13:0] rsv_base;
  logic        any_locked;
  logic        exec_locked;
  logic        on_lock_page;
  logic        bad;
  logic        fw_ok;

  always_comb begin
    lock_base    = rq.big_flash ? FSG_LOCK_PAGE_BIG : FSG_LOCK_PAGE_SML;
    lock_byte    = rq.big_flash ? FSG_LOCK_PAGE_END_BIG
                                : FSG_LOCK_PAGE_END_SML;
    rsv_base     = rq.big_flash ? FSG_RSV_BASE_BIG : FSG_RSV_BASE_SML;
    any_locked   = rq.lock_n != 8'h00;
    on_lock_page = rq.addr[13:9] == lock_base[13:9];
    // Executing page decides the firmware class on this same access
    exec_locked  = fsg_page_locked(rq.pc_addr[13:9], rq.lock_n)
                   | (any_locked & rq.pc_addr[13:9] == lock_base[13:9]);
    bad   = 1'b0;
    fw_ok = 1'b0;
    if (rq.op == FSG_OP_ERASE_ALL) begin
      bad = !rq.is_dbg;
    end else if (rq.addr >= rsv_base) begin
      bad = 1'b1;
    end else if (on_lock_page) begin
      if (rq.op == FSG_OP_ERASE_PAGE) begin
        bad = !rq.is_dbg | any_locked;
      end else if (rq.op == FSG_OP_WRITE && rq.addr == lock_byte &&
                   rq.lock_written) begin
        bad = 1'b1;
      end else if (any_locked) begin
        bad   = 1'b1;
        fw_ok = exec_locked;
      end
    end else if (fsg_page_locked(rq.addr[13:9], rq.lock_n)) begin
      bad   = 1'b1;
      fw_ok = exec_locked;
    end
    // Unlocked pages fall through as permitted
    if (!bad || (!rq.is_dbg && fw_ok)) begin
      rq.verdict = FSG_PERMIT;
    end else if (rq.is_dbg) begin
      rq.verdict = FSG_IGNORE;
    end else begin
      rq.verdict = FSG_FAULT;
    end
  end

endmodule : fsg_judge

// ### rtl/fsg_top.sv
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module fsg_top
  import fsg_pkg::*;
#(
  parameter bit BIG_FLASH = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        por_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Stored lock byte as the flash array holds it
  input  wire logic [7:0]  lock_byte_i,
  // Debug two-wire port requests
  input  wire logic        dbg_req_i,
  input  wire fsg_op_e     dbg_op_i,
  input  wire logic [13:0] dbg_addr_i,
  input  wire logic [7:0]  dbg_wdata_i,
  output logic             dbg_done_o,
  output fsg_verdict_e     dbg_verdict_o,
  // Firmware requests: code read, or store write (page erase while see is set)
  input  wire logic        fw_req_i,
  input  wire logic        fw_write_i,
  input  wire logic [13:0] fw_addr_i,
  input  wire logic [13:0] fw_pc_i,
  input  wire logic [7:0]  fw_wdata_i,
  output logic             fw_done_o,
  output fsg_verdict_e     fw_verdict_o,
  output logic             guard_ready_o,
  // Flash array command side
  output logic             fl_cmd_valid_o,
  output fsg_op_e          fl_op_o,
  output logic [13:0]      fl_addr_o,
  output logic [7:0]       fl_wdata_o,
  input  wire logic        fl_done_i,
  output logic             irq_hold_o,
  output logic             flash_err_rst_o
);

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_RESP, ST_WAIT} fsg_state_e;

  fsg_state_e   state_q;
  fsg_state_e   state_d;
  logic [7:0]   lock_q;
  logic         lock_written_q;
  logic         swe_q;
  logic         see_q;
  logic         src_dbg_q;
  fsg_verdict_e verdict_q;
  logic         err_cause_q;
  logic         ferr_flag_q;
  logic         por_flag_q;
  logic         seen_run_q;
  logic         take;
  logic         fw_nostore;
  fsg_op_e      fw_op;
  fsg_verdict_e verdict;
  logic [13:0]  lock_byte_addr;
  logic         aw_held_q;
  logic         w_held_q;
  logic [7:0]   aw_addr_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;

  fsg_req_if rq ();

  fsg_judge u_judge (
    .rq (rq)
  );

  always_comb begin
    lock_byte_addr = BIG_FLASH ? FSG_LOCK_PAGE_END_BIG : FSG_LOCK_PAGE_END_SML;
    take       = guard_ready_o & (dbg_req_i | fw_req_i);
    // Without write-enable a firmware write never reaches the store
    fw_nostore = fw_write_i & !swe_q;
    if (!fw_write_i) begin
      fw_op = FSG_OP_READ;
    end else if (see_q) begin
      fw_op = FSG_OP_ERASE_PAGE;
    end else begin
      fw_op = FSG_OP_WRITE;
    end
    rq.is_dbg       = dbg_req_i;
    rq.op           = dbg_req_i ? dbg_op_i : fw_op;
    rq.addr         = dbg_req_i ? dbg_addr_i : fw_addr_i;
    rq.pc_addr      = fw_pc_i;
    rq.lock_n       = ~lock_q;
    rq.lock_written = lock_written_q;
    rq.big_flash    = BIG_FLASH;
    verdict = (!dbg_req_i && fw_nostore) ? FSG_IGNORE : rq.verdict;
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_LOAD: state_d = ST_IDLE;
      ST_IDLE: begin
        if (take) begin
          if (verdict == FSG_PERMIT && rq.op != FSG_OP_READ) begin
            state_d = ST_WAIT;
          end else begin
            state_d = ST_RESP;
          end
        end
      end
      ST_RESP: state_d = ST_IDLE;
      ST_WAIT: begin
        // One answer cycle keeps ready low while the held request drops
        if (fl_done_i) begin
          state_d = ST_RESP;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q       <= ST_LOAD;
      guard_ready_o <= 1'b0;
      irq_hold_o    <= 1'b0;
    end else begin
      state_q       <= state_d;
      guard_ready_o <= state_d == ST_IDLE;
      irq_hold_o    <= state_d == ST_WAIT;
    end
  end

  // Lock count is only ever loaded here, so a fresh write waits for reset; the written flag sets at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_q         <= FSG_LOCK_ERASED;
      lock_written_q <= 1'b0;
    end else if (state_q == ST_LOAD) begin
      lock_q         <= lock_byte_i;
      lock_written_q <= lock_byte_i != FSG_LOCK_ERASED;
    end else if (take && verdict == FSG_PERMIT) begin
      if (rq.op == FSG_OP_ERASE_ALL) begin
        lock_q         <= FSG_LOCK_ERASED;
        lock_written_q <= 1'b0;
      end else if (rq.op == FSG_OP_WRITE && rq.addr == lock_byte_addr) begin
        lock_written_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fl_cmd_valid_o  <= 1'b0;
      fl_op_o         <= FSG_OP_READ;
      fl_addr_o       <= 14'h0000;
      fl_wdata_o      <= 8'h00;
      flash_err_rst_o <= 1'b0;
      src_dbg_q       <= 1'b0;
      verdict_q       <= FSG_PERMIT;
    end else begin
      fl_cmd_valid_o  <= take && verdict == FSG_PERMIT;
      flash_err_rst_o <= take && verdict == FSG_FAULT;
      if (take) begin
        fl_op_o    <= rq.op;
        fl_addr_o  <= rq.addr;
        fl_wdata_o <= dbg_req_i ? dbg_wdata_i : fw_wdata_i;
        src_dbg_q  <= dbg_req_i;
        verdict_q  <= verdict;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dbg_done_o    <= 1'b0;
      fw_done_o     <= 1'b0;
      dbg_verdict_o <= FSG_PERMIT;
      fw_verdict_o  <= FSG_PERMIT;
    end else begin
      dbg_done_o <= 1'b0;
      fw_done_o  <= 1'b0;
      if ((state_q == ST_IDLE && state_d == ST_RESP) ||
          (state_q == ST_WAIT && fl_done_i)) begin
        if (state_q == ST_IDLE ? dbg_req_i : src_dbg_q) begin
          dbg_done_o    <= 1'b1;
          dbg_verdict_o <= state_q == ST_IDLE ? verdict : verdict_q;
        end else begin
          fw_done_o    <= 1'b1;
          fw_verdict_o <= state_q == ST_IDLE ? verdict : verdict_q;
        end
      end
    end
  end

  // Reset cause survives the device reset it triggers; the next device reset without a fault, or power-on, clears it
  always_ff @(posedge clk_i) begin
    if (!por_n_i) begin
      err_cause_q <= 1'b0;
      ferr_flag_q <= 1'b0;
      por_flag_q  <= 1'b1;
      seen_run_q  <= 1'b0;
    end else if (!rst_n_i) begin
      if (seen_run_q) begin
        ferr_flag_q <= err_cause_q;
        por_flag_q  <= 1'b0;
        err_cause_q <= 1'b0;
      end
      seen_run_q <= 1'b0;
    end else begin
      seen_run_q <= 1'b1;
      if (take && verdict == FSG_FAULT) begin
        err_cause_q <= 1'b1;
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= FSG_RESP_OKAY;
      swe_q         <= FSG_STORE_CTRL_RST[FSG_SWE_BIT];
      see_q         <= FSG_STORE_CTRL_RST[FSG_SEE_BIT];
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (aw_held_q && w_held_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= FSG_RESP_OKAY;
        unique case ({aw_addr_q[7:2], 2'b00})
          FSG_REG_STORE_CTRL: begin
            if (w_strb_q[0]) begin
              swe_q <= w_data_q[FSG_SWE_BIT];
              see_q <= w_data_q[FSG_SEE_BIT];
            end
          end
          FSG_REG_RST_SRC, FSG_REG_STATUS: ;
          default: s_axi_bresp <= FSG_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= FSG_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= FSG_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        unique case ({s_axi_araddr[7:2], 2'b00})
          FSG_REG_STORE_CTRL: begin
            s_axi_rdata[FSG_SWE_BIT] <= swe_q;
            s_axi_rdata[FSG_SEE_BIT] <= see_q;
          end
          FSG_REG_RST_SRC: begin
            s_axi_rdata[FSG_POR_BIT]  <= por_flag_q;
            s_axi_rdata[FSG_FERR_BIT] <= ferr_flag_q;
          end
          FSG_REG_STATUS: begin
            s_axi_rdata[FSG_ST_LOCK_LSB +: 8]  <= lock_q;
            s_axi_rdata[FSG_ST_ANY_BIT]      <= lock_q != FSG_LOCK_ERASED;
            s_axi_rdata[FSG_ST_WRITTEN_BIT]  <= lock_written_q;
            s_axi_rdata[FSG_ST_BUSY_BIT]     <= state_q == ST_WAIT;
          end
          default: s_axi_rresp <= FSG_RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : fsg_top

// ### tb/fsg_top_sva.sv
`timescale 1ns/10ps
module fsg_top_sva
  import fsg_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic         fw_req_i,
  input wire logic         fw_write_i,
  input wire logic         dbg_req_i,
  input wire logic         guard_ready_o,
  input wire logic         fw_done_o,
  input wire fsg_verdict_e fw_verdict_o,
  input wire logic         dbg_done_o,
  input wire fsg_verdict_e dbg_verdict_o,
  input wire logic         fl_cmd_valid_o,
  input wire fsg_op_e      fl_op_o,
  input wire logic         fl_done_i,
  input wire logic         irq_hold_o,
  input wire logic         flash_err_rst_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_flash_end;
    irq_hold_o && fl_done_i;
  endsequence
  sequence s_fw_read_take;
    guard_ready_o && fw_req_i && !fw_write_i && !dbg_req_i;
  endsequence
  sequence s_long_op;
    fl_cmd_valid_o && fl_op_o != FSG_OP_READ;
  endsequence

  a_err_is_fault: assert property (
    flash_err_rst_o |-> ##[0:1] (fw_verdict_o == FSG_FAULT))
    else $error("device reset without a firmware fault");
  a_err_one_pulse: assert property (
    flash_err_rst_o |=> !flash_err_rst_o)
    else $error("error reset request longer than one cycle");
  a_dbg_no_fault: assert property (
    dbg_done_o |-> dbg_verdict_o != FSG_FAULT)
    else $error("debug access ended in a fault");
  a_dbg_quiet_drop: assert property (
    dbg_done_o && dbg_verdict_o == FSG_IGNORE
      |-> !fl_cmd_valid_o && !flash_err_rst_o)
    else $error("ignored debug access reached the array");
  a_fw_refused_idle: assert property (
    fw_done_o && fw_verdict_o != FSG_PERMIT |-> !fl_cmd_valid_o)
    else $error("refused firmware access reached the array");
  a_read_answer: assert property (
    s_fw_read_take |=> fw_done_o)
    else $error("firmware read not answered next cycle");
  a_hold_irq_start: assert property (
    s_long_op |-> irq_hold_o)
    else $error("interrupts not held during write or erase");
  a_hold_irq_stays: assert property (
    irq_hold_o && !fl_done_i |=> irq_hold_o)
    else $error("interrupt hold dropped before array finished");
  a_flash_end_done: assert property (
    s_flash_end |=> !irq_hold_o && (fw_done_o || dbg_done_o))
    else $error("write or erase not completed after array done");
endmodule : fsg_top_sva

bind fsg_top fsg_top_sva i_fsg_top_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .fw_req_i(fw_req_i),
  .fw_write_i(fw_write_i), .dbg_req_i(dbg_req_i),
  .guard_ready_o(guard_ready_o), .fw_done_o(fw_done_o),
  .fw_verdict_o(fw_verdict_o), .dbg_done_o(dbg_done_o),
  .dbg_verdict_o(dbg_verdict_o), .fl_cmd_valid_o(fl_cmd_valid_o),
  .fl_op_o(fl_op_o), .fl_done_i(fl_done_i), .irq_hold_o(irq_hold_o),
  .flash_err_rst_o(flash_err_rst_o)
);

// ### tb/fsg_flash_model.sv
`timescale 1ns/10ps
module fsg_flash_model
  import fsg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cmd_valid_i,
  input  wire fsg_op_e    op_i,
  input  wire logic [3:0] lat_i,
  output logic            done_o
);
  logic [3:0] cnt_q;

  // Reads finish inside the guard, so only writes and erases get an answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 4'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_q == 4'h1);
      if (cmd_valid_i && op_i != FSG_OP_READ) cnt_q <= lat_i;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : fsg_flash_model

// ### tb/flash_security_access_guard_tb_top.sv
`timescale 1ns/10ps
module flash_security_access_guard_tb_top;
  import fsg_pkg::*;
  localparam fsg_verdict_e VP = FSG_PERMIT, VI = FSG_IGNORE, VF = FSG_FAULT;
  localparam fsg_op_e RD = FSG_OP_READ, WR = FSG_OP_WRITE;
  localparam fsg_op_e PE = FSG_OP_ERASE_PAGE, EA = FSG_OP_ERASE_ALL;
  logic         clk_i = 1'b0, rst_n_i = 1'b0, por_n_i = 1'b0;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00, lock_b = 8'hFD;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic         arvalid = 1'b0, rready = 1'b0;
  logic [31:0]  wdata = 32'h0, rdata;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  logic         dbg_req = 1'b0, fw_req = 1'b0, fw_wr = 1'b0;
  fsg_op_e      dbg_op = FSG_OP_READ, fl_op;
  logic [13:0]  dbg_addr = 14'h0, fw_addr = 14'h0, fw_pc = 14'h0, fl_addr;
  logic [7:0]   fl_wd;
  logic         dbg_done, fw_done, g_rdy, cmd_v, fl_done, irq_hold, err_rst;
  fsg_verdict_e dbg_v, fw_v;
  logic [3:0]   lat = 4'h1;
  int           fails = 0, num_checks = 0;

  always #50 clk_i = ~clk_i;

  fsg_top #(.BIG_FLASH(1'b1)) i_fsg_top (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lock_byte_i(lock_b),
    .dbg_req_i(dbg_req), .dbg_op_i(dbg_op), .dbg_addr_i(dbg_addr),
    .dbg_wdata_i(dbg_addr[7:0]), .dbg_done_o(dbg_done),
    .dbg_verdict_o(dbg_v), .fw_req_i(fw_req), .fw_write_i(fw_wr),
    .fw_addr_i(fw_addr), .fw_pc_i(fw_pc), .fw_wdata_i(fw_addr[7:0]),
    .fw_done_o(fw_done), .fw_verdict_o(fw_v), .guard_ready_o(g_rdy),
    .fl_cmd_valid_o(cmd_v), .fl_op_o(fl_op), .fl_addr_o(fl_addr),
    .fl_wdata_o(fl_wd), .fl_done_i(fl_done), .irq_hold_o(irq_hold),
    .flash_err_rst_o(err_rst)
  );

  fsg_flash_model i_fsg_flash_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_v), .op_i(fl_op),
    .lat_i(lat), .done_o(fl_done)
  );

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic do_reset(input logic por);
    rst_n_i <= 1'b0;
    por_n_i <= !por;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : do_reset

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    chk("bresp", {29'h0, !bvalid, bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    chk("rresp", {29'h0, !rvalid, rresp}, {30'h0, er});
    if (er == FSG_RESP_OKAY) chk("rdata", rdata, exp);
  endtask : axi_rd

  // Debug or firmware request; op is what the array should be told to do
  task automatic req(input logic dbg, input fsg_op_e op,
                     input logic [13:0] a, pc, input fsg_verdict_e ev);
    int n;
    logic cmd, err, dn;
    logic [23:0] seen;
    fsg_verdict_e v;
    n = 0;
    cmd = 1'b0;
    err = 1'b0;
    seen = 24'h0;
    if (dbg) begin
      dbg_req <= 1'b1;
      dbg_op <= op;
      dbg_addr <= a;
    end else begin
      fw_req <= 1'b1;
      fw_wr <= (op != RD);
      fw_addr <= a;
      fw_pc <= pc;
    end
    do begin
      @(posedge clk_i);
      n++;
      if (cmd_v) cmd = 1'b1;
      if (cmd_v) seen = {fl_op, fl_addr, fl_wd};
      err |= err_rst;
      dn = dbg ? dbg_done : fw_done;
      v = dbg ? dbg_v : fw_v;
    end while (!dn && n < 200);
    dbg_req <= 1'b0;
    fw_req <= 1'b0;
    @(posedge clk_i);
    err |= err_rst;
    chk("verdict", {29'h0, !dn, v}, {30'h0, ev});
    chk("cmd err", {30'h0, cmd, err}, {30'h0, ev == VP, ev == VF});
    if (cmd) chk("op addr", {8'h0, seen}, {8'h0, op, a, a[7:0]});
  endtask : req

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    end_of_test();
  end

  initial begin
    do_reset(1'b1);
    axi_rd(8'h00, 32'h0, FSG_RESP_OKAY);
    axi_rd(8'h04, 32'h1, FSG_RESP_OKAY);
    axi_rd(8'h08, 32'h3FD, FSG_RESP_OKAY);
    axi_rd(8'h0C, 32'h0, FSG_RESP_SLVERR);
    axi_wr(8'h10, 32'h1, FSG_RESP_SLVERR);
    axi_wr(8'h04, 32'h1, FSG_RESP_OKAY);
    axi_rd(8'h04, 32'h1, FSG_RESP_OKAY);
    $display("test registers done");
    req(1'b1, RD, 14'h0000, 14'h0, VI);
    req(1'b1, RD, 14'h03FF, 14'h0, VI);
    req(1'b1, RD, 14'h0400, 14'h0, VP);
    req(1'b1, WR, 14'h3C00, 14'h0, VI);
    req(1'b1, RD, 14'h3DFF, 14'h0, VI);
    req(1'b1, WR, 14'h3DFF, 14'h0, VI);
    req(1'b1, RD, 14'h3E00, 14'h0, VI);
    req(1'b1, PE, 14'h0400, 14'h0, VP);
    $display("test debug locked done");
    req(1'b0, WR, 14'h0600, 14'h0400, VI);
    axi_wr(8'h00, 32'h2, FSG_RESP_OKAY);
    req(1'b0, WR, 14'h0600, 14'h0400, VI);
    axi_wr(8'h00, 32'h1, FSG_RESP_OKAY);
    req(1'b0, WR, 14'h0600, 14'h0400, VP);
    lat <= 4'h6;
    axi_wr(8'h00, 32'h3, FSG_RESP_OKAY);
    req(1'b0, PE, 14'h0600, 14'h0400, VP);
    req(1'b0, RD, 14'h0200, 14'h0000, VP);
    req(1'b0, RD, 14'h3DFF, 14'h0000, VP);
    req(1'b0, PE, 14'h3C00, 14'h0000, VF);
    req(1'b0, RD, 14'h3E10, 14'h0000, VF);
    req(1'b0, RD, 14'h0000, 14'h0400, VF);
    do_reset(1'b0);
    axi_rd(8'h04, 32'h2, FSG_RESP_OKAY);
    axi_rd(8'h00, 32'h0, FSG_RESP_OKAY);
    $display("test firmware locked done");
    req(1'b1, EA, 14'h0000, 14'h0, VP);
    axi_rd(8'h08, 32'hFF, FSG_RESP_OKAY);
    req(1'b1, RD, 14'h0000, 14'h0, VP);
    $display("test device erase done");
    lat <= 4'h1;
    lock_b <= 8'hFF;
    do_reset(1'b1);
    req(1'b0, RD, 14'h3DFF, 14'h0400, VP);
    req(1'b1, WR, 14'h3C00, 14'h0, VP);
    req(1'b1, PE, 14'h3C00, 14'h0, VP);
    axi_wr(8'h00, 32'h3, FSG_RESP_OKAY);
    req(1'b0, PE, 14'h3C00, 14'h0000, VF);
    axi_wr(8'h00, 32'h1, FSG_RESP_OKAY);
    req(1'b0, WR, 14'h3DFF, 14'h0400, VP);
    axi_rd(8'h08, 32'h2FF, FSG_RESP_OKAY);
    lock_b <= 8'hFE;
    do_reset(1'b0);
    axi_rd(8'h08, 32'h3FE, FSG_RESP_OKAY);
    req(1'b0, RD, 14'h0000, 14'h0400, VF);
    req(1'b0, RD, 14'h0200, 14'h0400, VP);
    req(1'b1, WR, 14'h3DFF, 14'h0, VI);
    $display("test lock byte done");
    end_of_test();
  end
endmodule : flash_security_access_guard_tb_top
